// ===== design/supply_trip_detector.v
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "voltage_detect_regs.vh"

// What this block does
// - the analog detector is powered only while the enable bit 4 is set.
// - after each enable the stable flag in bit 5 reads zero until the settle time ends, then one.
// - the detect flag cannot be set while the stable flag is clear.
// - direction bit 7 set trips at or above the trip point, clear trips at or below it.
// - a trip in the selected direction sets the detect interrupt flag.
// - trip-point field codes 0000 to 1110 select divider taps from lowest to highest.
// - trip-point code 1111 routes the external detect pin to the comparator while the enable bit 4 is set.
// - bit 6 ignores writes and reads as zero.
// - the settle interval is a fixed count of clock cycles (SETTLE_COUNT), so its length scales with clock period, and trips within it are lost.
module supply_trip_detector #(
	parameter SETTLE_COUNT = `SETTLE_CYCLES,
	parameter COUNT_WIDTH  = 16
) (
	// clock and reset
	input  wire                    clock,
	input  wire                    srst,
	// register port
	input  wire [`ADDR_WIDTH-1:0]  addr,
	input  wire [7:0]              wdata,
	input  wire                    wr_stb,
	input  wire                    rd_stb,
	output reg  [7:0]              rdata,
	// analog front end
	input  wire                    above_trip,
	input  wire                    below_trip,
	output reg                     detector_power,
	output reg  [3:0]              divider_tap,
	output reg                     external_select,
	// interrupt
	output reg                     irq
);

	localparam [COUNT_WIDTH-1:0] SETTLE_LAST = SETTLE_COUNT - 1;

	reg                    dir_reg;
	reg                    enable_reg;
	reg [3:0]              trip_reg;
	reg                    stable_reg;
	reg [COUNT_WIDTH-1:0]  settle_reg;
	reg                    status_reg;
	reg                    mask_reg;
	reg                    above_meta_reg;
	reg                    above_sync_reg;
	reg                    below_meta_reg;
	reg                    below_sync_reg;

	wire                   wr_ctrl;
	wire                   wr_status;
	wire                   wr_mask;
	wire                   trip_hit;
	wire                   detect_set;
	wire                   status_next;
	wire                   mask_next;
	wire [7:0]             ctrl_view;

	function sel;
		input [`ADDR_WIDTH-1:0] a;
		input [`ADDR_WIDTH-1:0] target;
		begin
			sel = (a == target);
		end
	endfunction

	assign wr_ctrl   = wr_stb && sel(addr, `ADDR_CONTROL);
	assign wr_status = wr_stb && sel(addr, `ADDR_IRQ_STATUS);
	assign wr_mask   = wr_stb && sel(addr, `ADDR_IRQ_MASK);

	// comparator outputs are asynchronous to the clock
	always @(posedge clock) begin
		if (srst) begin
			above_meta_reg <= 1'b0;
			above_sync_reg <= 1'b0;
			below_meta_reg <= 1'b0;
			below_sync_reg <= 1'b0;
		end else begin
			above_meta_reg <= above_trip;
			above_sync_reg <= above_meta_reg;
			below_meta_reg <= below_trip;
			below_sync_reg <= below_meta_reg;
		end
	end

	// control register
	always @(posedge clock) begin
		if (srst) begin
			dir_reg    <= `CTRL_DIR_RESET;
			enable_reg <= 1'b0;
			trip_reg   <= `CTRL_TRIP_RESET;
		end else if (wr_ctrl) begin
			dir_reg    <= wdata[`CTRL_DIR_BIT];
			enable_reg <= wdata[`CTRL_ENABLE_BIT];
			trip_reg   <= wdata[`CTRL_TRIP_MSB:`CTRL_TRIP_LSB];
		end
	end

	// settle timer: counts only while enabled, so any disable restarts it
	always @(posedge clock) begin
		if (srst || !enable_reg) begin
			settle_reg <= {COUNT_WIDTH{1'b0}};
			stable_reg <= 1'b0;
		end else if (settle_reg == SETTLE_LAST) begin
			stable_reg <= 1'b1;
		end else begin
			settle_reg <= settle_reg + 1'b1;
		end
	end

	// at-or-above vs at-or-below, qualified by stable
	assign trip_hit   = dir_reg ? above_sync_reg : below_sync_reg;
	assign detect_set = enable_reg && stable_reg && trip_hit;
	// set beats write-one-to-clear
	assign status_next = detect_set |
		(status_reg & ~(wr_status & wdata[`IRQ_DETECT_BIT]));
	// irq follows a mask write at the same edge, no stale cycle
	assign mask_next = wr_mask ? wdata[`IRQ_DETECT_BIT] : mask_reg;

	always @(posedge clock) begin
		if (srst) begin
			status_reg <= `IRQ_RESET;
			mask_reg   <= `IRQ_RESET;
		end else begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
		end
	end

	assign ctrl_view = {dir_reg, 1'b0, stable_reg, enable_reg, trip_reg};

	// registered outputs
	always @(posedge clock) begin
		if (srst) begin
			rdata           <= 8'h00;
			detector_power  <= 1'b0;
			divider_tap     <= 4'h0;
			external_select <= 1'b0;
			irq             <= 1'b0;
		end else begin
			detector_power  <= enable_reg;
			// tap code 1111 is not a divider tap; keep the divider parked at maximum
			divider_tap     <= (trip_reg == `TRIP_EXTERNAL) ? `TRIP_MAXIMUM : trip_reg;
			external_select <= enable_reg && (trip_reg == `TRIP_EXTERNAL);
			irq             <= status_next & mask_next;
			if (rd_stb) begin
				if (sel(addr, `ADDR_CONTROL))
					rdata <= ctrl_view;
				else if (sel(addr, `ADDR_IRQ_STATUS))
					rdata <= {7'h00, status_reg};
				else if (sel(addr, `ADDR_IRQ_MASK))
					rdata <= {7'h00, mask_reg};
				else
					rdata <= 8'h00;
			end else begin
				rdata <= 8'h00;
			end
		end
	end

endmodule // supply_trip_detector
`default_nettype wire

// ===== design/voltage_detect_regs.vh
`ifndef VOLTAGE_DETECT_REGS_VH
`define VOLTAGE_DETECT_REGS_VH

// register map (byte addresses)
`define ADDR_CONTROL      4'h0
`define ADDR_IRQ_STATUS   4'h4
`define ADDR_IRQ_MASK     4'h8
`define ADDR_WIDTH        4

// control register fields
`define CTRL_DIR_BIT      7
`define CTRL_UNUSED_BIT   6
`define CTRL_STABLE_BIT   5
`define CTRL_ENABLE_BIT   4
`define CTRL_TRIP_MSB     3
`define CTRL_TRIP_LSB     0
`define CTRL_RESET        8'h05
`define CTRL_WRITE_MASK   8'h9F
`define CTRL_DIR_RESET    1'b0
`define CTRL_TRIP_RESET   4'h5

// trip point codes
`define TRIP_EXTERNAL     4'hF
`define TRIP_MAXIMUM      4'hE
`define TRIP_MINIMUM      4'h0

// interrupt status bits
`define IRQ_DETECT_BIT    0
`define IRQ_WIDTH         1
`define IRQ_RESET         1'h0

// settle time
`define SETTLE_TIME_NS    20000
`define CLOCK_PERIOD_NS   20
`define SETTLE_CYCLES     ((`SETTLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ===== sim/detect_props.sv
`timescale 1ns/1ns
`default_nettype none
module detect_props (
	// watched ports
	input wire logic       clock,
	input wire logic       srst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] rdata,
	input wire logic       detector_power,
	input wire logic [3:0] divider_tap,
	input wire logic       external_select,
	input wire logic       irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	wire logic       wc      = wr_stb && addr == 4'h0;
	wire logic [3:0] tap_exp = wdata[3:0] == 4'hF ? 4'hE : wdata[3:0];
	wire logic       ext_exp = wdata[4] && wdata[3:0] == 4'hF;
	pwr_follow_a: assert property (wc |-> ##2 detector_power == $past(wdata[4], 2))
		else $error("power");
	tap_follow_a: assert property (wc |-> ##2 divider_tap == $past(tap_exp, 2))
		else $error("tap");
	ext_follow_a: assert property (wc |-> ##2 external_select == $past(ext_exp, 2))
		else $error("ext");
	ext_power_a: assert property (external_select |-> detector_power)
		else $error("ext off");
	bit6_zero_a: assert property (rd_stb |=> !rdata[6])
		else $error("bit6");
	unmapped_zero_a: assert property (rd_stb && addr > 4'h8 |=> rdata == 8'h00)
		else $error("unmapped");
	// no mask write in the window, so only a premature detect can raise irq
	settle_quiet_a: assert property ($rose(detector_power) && !irq ##1 !wr_stb [*2] |-> !irq)
		else $error("settle");
	mask_gate_a: assert property (wr_stb && addr == 4'h8 && !wdata[0] |=> !irq)
		else $error("mask");
	cover property (wc ##2 external_select);
	cover property ($rose(irq));
	cover property (rd_stb && addr == 4'h4 ##1 rdata[0]);
endmodule // detect_props
`default_nettype wire

// ===== sim/supply_trip_detector_tb.sv
`timescale 1ns/1ns
`default_nettype none
module supply_trip_detector_tb;
	logic       clock = 0, srst = 1, wr_stb = 0, rd_stb = 0, above_trip = 0, below_trip = 0;
	logic [3:0] addr = 0, divider_tap;
	logic [7:0] wdata = 0, rdata, v;
	logic       detector_power, external_select, irq;
	int         failures = 0, cmp_count = 0, cyc = 0, i;
	// short settle keeps the run brief
	supply_trip_detector #(.SETTLE_COUNT(4)) u_dut (.clock, .srst, .addr, .wdata, .wr_stb,
		.rd_stb, .rdata, .above_trip, .below_trip, .detector_power, .divider_tap,
		.external_select, .irq);
	initial forever #10 clock = ~clock;
	task chk(input string n, input logic [7:0] g, e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		wr_stb <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr_stb <= 0;
		#1;
	endtask
	task rd(input string n, input logic [3:0] a, input logic [7:0] e);
		rd_stb <= 1;
		addr <= a;
		@(posedge clock);
		rd_stb <= 0;
		#1 chk(n, rdata, e);
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h4A69));
		repeat (3) @(posedge clock);
		srst <= 0;
		rd("ctrl", 4'h0, 8'h05);
		for (i = 0; i < 16; i++) begin
			v = 8'($urandom) & 8'hC0 | 8'h10 | 8'(i);
			wr(4'h0, v);
			@(posedge clock);
			#1 chk("tap", {4'h0, divider_tap}, i == 15 ? 8'h0E : 8'(i));
			rd("ctrl", 4'h0, v & 8'h9F);
			wr(4'h0, v & 8'hEF);
		end
		$display("test taps done");
		for (i = 0; i < 2; i++) begin
			wr(4'h0, 8'h13 | 8'(i << 7));
			above_trip <= i[0];
			below_trip <= !i[0];
			repeat (8) @(posedge clock);
			rd("ctrl", 4'h0, 8'h33 | 8'(i << 7));
			wr(4'h4, 8'h01);
			wr(4'h8, 8'h01);
			chk("irq", {7'h0, irq}, 8'h01);
			rd("stat", 4'h4, 8'h01);
			wr(4'h8, 8'h00);
			above_trip <= !i[0];
			below_trip <= i[0];
			repeat (4) @(posedge clock);
			wr(4'h4, 8'h01);
			repeat (4) @(posedge clock);
			rd("stat", 4'h4, 8'h00);
			wr(4'h0, 8'h05);
		end
		$display("test detect done");
		rd("none", 4'hC, 8'h00);
		report_and_stop;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc > 2000) begin
			failures++;
			report_and_stop;
		end
	end
endmodule // supply_trip_detector_tb
bind supply_trip_detector detect_props u_props (.clock, .srst, .addr, .wdata, .wr_stb,
	.rd_stb, .rdata, .detector_power, .divider_tap, .external_select, .irq);
`default_nettype wire
